// *** verilog/setws_dev.sv ***
// EEPROM slave end: two-wire slave port, 256x8 array, RC-timed erase/write
// How it works
// [RQ1] Answer only when chip field matches straps
// [RQ2] Master starts transfers only on idle bus
// [RQ3] SDA stable while SCL high
// [RQ4] Both lines high means bus idle
// [RQ5] START: SDA falls while SCL high
// [RQ6] STOP: SDA rises while SCL high
// [RQ7] One bit per SCL pulse, sampled high
// [RQ8] Master writes at most two data bytes
// [RQ9] Eight-bit bytes, ninth bit acknowledge
// [RQ10] Master always supplies ninth clock pulse
// [RQ11] Addressed receiving slave acknowledges every byte; the slave refuses its address during erase/write and a third write data byte
// [RQ12] Master acknowledges bytes it wants continued
// [RQ13] Acknowledger holds SDA low through ninth pulse
// [RQ14] Master ends read by withholding acknowledge
// [RQ15] Slave releases SDA when master withholds acknowledge
// [RQ16] Works from slow to full bus rate
// [RQ17] Erase/write time set by RC network
// [RQ18] 2K bits of storage, byte accessed
// [RQ19] Write: word address, then up to two bytes
// [RQ20] Erase/write starts after STOP, per byte
// [RQ21] Pointer advances only on master acknowledge; the slave also advances it on each acknowledged write data byte
// [RQ22] Read without address uses current pointer
// [RQ23] Synchronise and deglitch SCL and SDA
// [RQ24] Pointer wraps from top to zero
`timescale 1ns/1ps
`default_nettype none
module setws_dev
  import setws_pkg::*;
(
  // Link
  setws_if.dev               link,
  input  wire logic          i_link_clk,
  // System clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  // Straps and timing network
  input  wire logic          i_chip_select_strap_bit0,
  input  wire logic          i_chip_select_strap_bit1,
  input  wire logic          i_chip_select_strap_bit2,
  input  wire logic          i_write_timing_network_input,
  // Erase/write status
  output logic               o_ew_busy,
  output logic               o_ew_charge
);
  // Link domain
  setws_dev_st_t state_r;
  setws_dev_st_t pend_r;
  logic [1:0]    scl_s_r;
  logic [1:0]    sda_s_r;
  logic [2:0]    strap_s_r;
  logic [2:0]    strap_r;
  logic [1:0]    filt_r;
  logic [1:0]    filt_q_r;
  logic [5:0]    flt_cnt_r [2];
  logic [3:0]    bit_r;
  logic [7:0]    sh_r;
  logic [7:0]    tx_r;
  logic          oe_n_r;
  logic          ack_go_r;
  logic [7:0]    ptr_r;
  logic [7:0]    base_r;
  logic [1:0]    wcnt_r;
  logic [7:0]    stage_r [2];
  logic          wr_arm_r;
  logic          busy_l_r;
  logic          req_tgl_r;
  logic [1:0]    ew_cnt_r;
  logic [2:0]    done_s_r;
  logic [7:0]    mem_r [MEM_WORDS];
  logic [1:0]    raw;
  logic          scl_f;
  logic          sda_f;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  logic          done_edge;
  logic [7:0]    byte_in;
  // System domain
  setws_ew_st_t  ew_st_r;
  logic [2:0]    req_s_r;
  logic [1:0]    tim_s_r;
  logic [1:0]    rem_r;
  logic          done_tgl_r;
  logic          req_edge;

  assign link.d_sda_o    = 1'b0;
  assign link.d_sda_oe_n = oe_n_r;
  assign raw       = {scl_s_r[1], sda_s_r[1]};
  assign scl_f     = filt_r[1];
  assign sda_f     = filt_r[0];
  assign scl_rise  = scl_f & ~filt_q_r[1];
  assign scl_fall  = ~scl_f & filt_q_r[1];
  assign start_det = scl_f & filt_q_r[1] & filt_q_r[0] & ~sda_f; // [RQ5]
  assign stop_det  = scl_f & filt_q_r[1] & ~filt_q_r[0] & sda_f; // [RQ6]
  assign done_edge = done_s_r[2] ^ done_s_r[1];
  assign byte_in   = {sh_r[6:0], sda_f};
  assign req_edge  = req_s_r[2] ^ req_s_r[1];

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s_r   <= SYNC_HI;
      sda_s_r   <= SYNC_HI;
      strap_s_r <= 3'h0;
      strap_r   <= 3'h0;
      done_s_r  <= 3'h0;
    end else begin
      scl_s_r   <= {scl_s_r[0], link.scl};
      sda_s_r   <= {sda_s_r[0], link.sda};
      strap_s_r <= {i_chip_select_strap_bit2, i_chip_select_strap_bit1, i_chip_select_strap_bit0};
      strap_r   <= strap_s_r;
      done_s_r  <= {done_s_r[1:0], done_tgl_r};
    end
  end

  // A level must hold for the whole noise window before it is believed;
  // no timeouts anywhere, so any SCL rate works
  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      filt_r       <= SYNC_HI;
      filt_q_r     <= SYNC_HI;
      flt_cnt_r[0] <= 6'h00;
      flt_cnt_r[1] <= 6'h00;
    end else begin
      filt_q_r <= filt_r;
      for (int k = 0; k < 2; k++) begin
        if (raw[k] == filt_r[k]) begin
          flt_cnt_r[k] <= 6'h00;
        end else if (flt_cnt_r[k] == FLT_LAST) begin // [RQ23] [RQ16]
          filt_r[k]    <= raw[k];
          flt_cnt_r[k] <= 6'h00;
        end else begin
          flt_cnt_r[k] <= flt_cnt_r[k] + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r   <= D_IDLE;
      pend_r    <= D_IDLE;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      tx_r      <= 8'hff;
      oe_n_r    <= 1'b1;
      ack_go_r  <= 1'b0;
      ptr_r     <= PTR_RST;
      base_r    <= PTR_RST;
      wcnt_r    <= 2'h0;
      stage_r[0] <= 8'h00;
      stage_r[1] <= 8'h00;
      wr_arm_r  <= 1'b0;
      busy_l_r  <= 1'b0;
      req_tgl_r <= 1'b0;
      ew_cnt_r  <= 2'h0;
    end else begin
      if (done_edge) begin
        busy_l_r <= 1'b0;
      end
      if (start_det) begin
        state_r  <= D_ADDR;
        bit_r    <= 4'h0;
        oe_n_r   <= 1'b1;
        wr_arm_r <= 1'b0;
      end else if (stop_det) begin
        state_r  <= D_IDLE;
        oe_n_r   <= 1'b1;
        wr_arm_r <= 1'b0;
        // Array is only touched once the master has let go of the bus
        if (wr_arm_r && wcnt_r != 2'h0) begin // [RQ20]
          busy_l_r  <= 1'b1;
          req_tgl_r <= ~req_tgl_r;
          ew_cnt_r  <= wcnt_r;
        end
      end else if (state_r == D_IDLE || state_r == D_SKIP) begin
        oe_n_r <= 1'b1; // [RQ4] [RQ15]
      end else if (scl_rise) begin // [RQ7]
        bit_r <= bit_r + 4'h1;
        sh_r  <= byte_in;
        if (bit_r == 4'h7) begin // [RQ9]
          unique case (state_r)
            D_ADDR: if (byte_in[7:4] == DEV_FAMILY && byte_in[3:1] == strap_r && !busy_l_r) begin // [RQ1]
              ack_go_r <= 1'b1;
              pend_r   <= byte_in[0] ? D_RDATA : D_WADDR; // [RQ22]
            end else begin
              ack_go_r <= 1'b0;
              pend_r   <= D_SKIP;
            end
            D_WADDR: begin // [RQ19]
              ptr_r    <= byte_in;
              base_r   <= byte_in;
              wcnt_r   <= 2'h0;
              wr_arm_r <= 1'b1;
              ack_go_r <= 1'b1;
              pend_r   <= D_WDATA;
            end
            D_WDATA: if (wcnt_r != MAX_WR_BYTES) begin
              stage_r[wcnt_r[0]] <= byte_in;
              wcnt_r   <= wcnt_r + 2'h1;
              ptr_r    <= ptr_r + 8'h01;
              ack_go_r <= 1'b1; // [RQ11]
              pend_r   <= D_WDATA;
            end else begin
              // A third byte is refused and the rest of the frame ignored
              ack_go_r <= 1'b0;
              pend_r   <= D_SKIP;
            end
            D_RDATA: begin
              ack_go_r <= 1'b0;
              pend_r   <= D_RDATA;
            end
            default: begin
              ack_go_r <= 1'b0;
              pend_r   <= D_SKIP;
            end
          endcase
        end else if (bit_r == ACK_BIT && state_r == D_RDATA) begin
          if (!sda_f) begin
            ptr_r <= ptr_r + 8'h01; // [RQ21] [RQ24]
          end else begin
            pend_r <= D_SKIP; // [RQ15]
          end
        end
      end else if (scl_fall) begin
        if (bit_r == ACK_BIT) begin
          oe_n_r <= ~ack_go_r; // [RQ11] [RQ13]
        end else if (bit_r == BYTE_END) begin
          bit_r   <= 4'h0;
          state_r <= pend_r;
          if (pend_r == D_RDATA) begin // [RQ21]
            tx_r   <= {mem_r[ptr_r][6:0], 1'b1};
            oe_n_r <= mem_r[ptr_r][7];
          end else begin
            oe_n_r <= 1'b1;
          end
        end else if (state_r == D_RDATA && bit_r != 4'h0) begin // [RQ3]
          oe_n_r <= tx_r[7];
          tx_r   <= {tx_r[6:0], 1'b1};
        end
      end
    end
  end

  // Storage is committed when the timed erase/write cycle finishes
  always_ff @(posedge i_link_clk) begin
    if (done_edge) begin // [RQ18]
      mem_r[base_r] <= stage_r[0];
      if (ew_cnt_r == MAX_WR_BYTES) begin
        mem_r[8'(base_r + 8'h01)] <= stage_r[1]; // [RQ24]
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_s_r <= 3'h0;
      tim_s_r <= 2'h0;
    end else begin
      req_s_r <= {req_s_r[1:0], req_tgl_r};
      tim_s_r <= {tim_s_r[0], i_write_timing_network_input};
    end
  end

  // One charge/discharge of the RC network per byte; SCL plays no part.
  // ew_cnt_r is held still by busy_l_r until the done toggle returns.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ew_st_r     <= E_IDLE;
      rem_r       <= 2'h0;
      done_tgl_r  <= 1'b0;
      o_ew_busy   <= 1'b0;
      o_ew_charge <= 1'b0;
    end else begin
      unique case (ew_st_r)
        E_IDLE: if (req_edge) begin
          rem_r       <= ew_cnt_r;
          o_ew_busy   <= 1'b1;
          o_ew_charge <= 1'b1;
          ew_st_r     <= E_CHARGE;
        end
        E_CHARGE: if (tim_s_r[1]) begin // [RQ17]
          o_ew_charge <= 1'b0;
          ew_st_r     <= E_SETTLE;
        end
        E_SETTLE: if (!tim_s_r[1]) begin // [RQ20]
          if (rem_r == 2'h1) begin
            o_ew_busy  <= 1'b0;
            done_tgl_r <= ~done_tgl_r;
            ew_st_r    <= E_IDLE;
          end else begin
            rem_r       <= rem_r - 2'h1;
            o_ew_charge <= 1'b1;
            ew_st_r     <= E_CHARGE;
          end
        end
        default: ew_st_r <= E_IDLE;
      endcase
    end
  end
endmodule // setws_dev
`default_nettype wire

// *** verilog/setws_pkg.sv ***
// Constants and types shared by both ends of the two-wire EEPROM link
package setws_pkg;
  localparam int          MEM_WORDS      = 256;
  localparam logic [3:0]  DEV_FAMILY     = 4'h5;  // Arbitrary value
  localparam logic [3:0]  ACK_BIT        = 4'h8;  // Bit count during acknowledge
  localparam logic [3:0]  BYTE_END       = 4'h9;
  localparam logic [1:0]  MAX_WR_BYTES   = 2'h2;
  localparam logic [7:0]  PTR_RST        = 8'h00;
  localparam logic [1:0]  SYNC_HI        = 2'h3;
  // Clocks and times
  localparam int          SYS_MHZ        = 100;
  localparam int          LINK_PERIOD_PS = 6000;
  localparam int          NOISE_PS       = 250000;  // 0.25 us glitch rejection
  localparam int          NOISE_CYC      = NOISE_PS / LINK_PERIOD_PS;
  localparam logic [5:0]  FLT_LAST       = 6'(NOISE_CYC - 1);
  localparam int          SCL_KHZ        = 100;
  localparam int          QTR_CYC        = (SYS_MHZ * 1000) / (SCL_KHZ * 4);
  localparam logic [7:0]  QTR_LAST       = 8'(QTR_CYC - 1);

  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_ADDR  = 3'h1,
    D_WADDR = 3'h2,
    D_WDATA = 3'h3,
    D_RDATA = 3'h4,
    D_SKIP  = 3'h5
  } setws_dev_st_t;

  typedef enum logic [1:0] {
    E_IDLE   = 2'h0,
    E_CHARGE = 2'h1,
    E_SETTLE = 2'h2
  } setws_ew_st_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_START = 3'h1,
    H_ADDRW = 3'h2,
    H_WADDR = 3'h3,
    H_WDATA = 3'h4,
    H_ADDRR = 3'h5,
    H_RDATA = 3'h6,
    H_STOP  = 3'h7
  } setws_host_st_t;
endpackage

// *** verilog/setws_if.sv ***
// Two-wire link between bus master and EEPROM slave, wired-AND lines
`timescale 1ns/1ps
`default_nettype none
interface setws_if;
  logic scl_o;
  logic scl_oe_n;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic scl;
  logic sda;

  // Pull-up wins unless some driver is enabled and low
  assign scl = ~(~scl_oe_n & ~scl_o);
  assign sda = ~((~h_sda_oe_n & ~h_sda_o) | (~d_sda_oe_n & ~d_sda_o));

  modport host (output scl_o, scl_oe_n, h_sda_o, h_sda_oe_n, input scl, sda);
  modport dev  (output d_sda_o, d_sda_oe_n, input scl, sda);
endinterface
`default_nettype wire

// *** verilog/setws_host.sv ***
// Bus master end: generates SCL, START/STOP, writes and reads the EEPROM
`timescale 1ns/1ps
`default_nettype none
module setws_host
  import setws_pkg::*;
#(
  parameter logic [7:0] P_QTR_LAST = QTR_LAST
) (
  // Link
  setws_if.host              link,
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_rst_n,
  // Command
  input  wire logic          i_cmd_valid,
  input  wire logic          i_cmd_read,
  input  wire logic          i_cmd_set_addr,
  input  wire logic [2:0]    i_cmd_chip,
  input  wire logic [7:0]    i_cmd_addr,
  input  wire logic [7:0]    i_cmd_count,
  input  wire logic [7:0]    i_cmd_wdata0,
  input  wire logic [7:0]    i_cmd_wdata1,
  // Status and read data
  output logic               o_busy,
  output logic               o_done,
  output logic               o_nack,
  output logic               o_rd_valid,
  output logic [7:0]         o_rd_data
);
  setws_host_st_t st_r;
  logic [1:0]     scl_s_r;
  logic [1:0]     sda_s_r;
  logic [7:0]     qcnt_r;
  logic [1:0]     phase_r;
  logic [3:0]     bit_r;
  logic [7:0]     tx_r;
  logic [7:0]     rx_r;
  logic [7:0]     rem_r;
  logic           ack_r;
  logic           rd_r;
  logic           seta_r;
  logic           addr_done_r;
  logic [2:0]     chip_r;
  logic [7:0]     addr_r;
  logic [7:0]     wd0_r;
  logic [7:0]     wd1_r;
  logic           scl_oe_n_r;
  logic           sda_oe_n_r;
  logic           tick;

  // Open-drain: only ever pull low
  assign link.scl_o      = 1'b0;
  assign link.h_sda_o    = 1'b0;
  assign link.scl_oe_n   = scl_oe_n_r;
  assign link.h_sda_oe_n = sda_oe_n_r;
  assign tick            = (st_r != H_IDLE) && (qcnt_r == P_QTR_LAST);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s_r <= SYNC_HI;
      sda_s_r <= SYNC_HI;
    end else begin
      scl_s_r <= {scl_s_r[0], link.scl};
      sda_s_r <= {sda_s_r[0], link.sda};
    end
  end

  // Quarter-period divider that paces SCL
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      qcnt_r <= 8'h00;
    end else if (st_r == H_IDLE || tick) begin
      qcnt_r <= 8'h00;
    end else begin
      qcnt_r <= qcnt_r + 8'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r        <= H_IDLE;
      phase_r     <= 2'h0;
      bit_r       <= 4'h0;
      tx_r        <= 8'hff;
      rx_r        <= 8'h00;
      rem_r       <= 8'h00;
      ack_r       <= 1'b1;
      rd_r        <= 1'b0;
      seta_r      <= 1'b0;
      addr_done_r <= 1'b0;
      chip_r      <= 3'h0;
      addr_r      <= 8'h00;
      wd0_r       <= 8'h00;
      wd1_r       <= 8'h00;
      scl_oe_n_r  <= 1'b1;
      sda_oe_n_r  <= 1'b1;
      o_busy      <= 1'b0;
      o_done      <= 1'b0;
      o_nack      <= 1'b0;
      o_rd_valid  <= 1'b0;
      o_rd_data   <= 8'h00;
    end else begin
      o_done     <= 1'b0;
      o_rd_valid <= 1'b0;
      unique case (st_r)
        H_IDLE: if (i_cmd_valid && scl_s_r[1] && sda_s_r[1]) begin // [RQ2]
          rd_r        <= i_cmd_read;
          seta_r      <= i_cmd_set_addr | ~i_cmd_read;
          chip_r      <= i_cmd_chip;
          addr_r      <= i_cmd_addr;
          wd0_r       <= i_cmd_wdata0;
          wd1_r       <= i_cmd_wdata1;
          // Writes carry one or two data bytes only
          rem_r       <= i_cmd_read ? ((i_cmd_count == 8'h00) ? 8'h01 : i_cmd_count)
                                    : ((i_cmd_count >= 8'h02) ? 8'h02 : 8'h01); // [RQ8]
          addr_done_r <= 1'b0;
          o_nack      <= 1'b0;
          o_busy      <= 1'b1;
          phase_r     <= 2'h0;
          st_r        <= H_START;
        end
        H_START: if (tick) begin
          phase_r <= phase_r + 2'h1;
          unique case (phase_r)
            2'h0: sda_oe_n_r <= 1'b1;
            2'h1: scl_oe_n_r <= 1'b1;
            2'h2: sda_oe_n_r <= 1'b0; // [RQ5]
            2'h3: begin
              scl_oe_n_r <= 1'b0;
              bit_r      <= 4'h0;
              if (seta_r && !addr_done_r) begin
                tx_r <= {DEV_FAMILY, chip_r, 1'b0};
                st_r <= H_ADDRW;
              end else begin
                tx_r <= {DEV_FAMILY, chip_r, 1'b1};
                st_r <= H_ADDRR;
              end
            end
          endcase
        end
        H_ADDRW, H_WADDR, H_WDATA, H_ADDRR, H_RDATA: if (tick) begin
          phase_r <= phase_r + 2'h1;
          unique case (phase_r)
            // Data changes only while SCL is low
            2'h0: sda_oe_n_r <= (bit_r == ACK_BIT) ? ~(st_r == H_RDATA && rem_r != 8'h01) // [RQ12] [RQ14]
                                                   : tx_r[7]; // [RQ3] [RQ7] [RQ13]
            2'h1: scl_oe_n_r <= 1'b1; // [RQ10]
            2'h2: if (bit_r == ACK_BIT) begin
              ack_r <= sda_s_r[1];
            end else begin
              rx_r <= {rx_r[6:0], sda_s_r[1]};
              tx_r <= {tx_r[6:0], 1'b1};
            end
            2'h3: begin
              scl_oe_n_r <= 1'b0;
              bit_r      <= bit_r + 4'h1;
              if (bit_r == ACK_BIT) begin // [RQ9]
                bit_r <= 4'h0;
                if (st_r != H_RDATA && ack_r) begin
                  o_nack <= 1'b1;
                  st_r   <= H_STOP;
                end else begin
                  unique case (st_r)
                    H_ADDRW: begin
                      tx_r <= addr_r;
                      st_r <= H_WADDR;
                    end
                    H_WADDR: begin // [RQ19]
                      addr_done_r <= 1'b1;
                      tx_r        <= wd0_r;
                      st_r        <= rd_r ? H_START : H_WDATA;
                    end
                    H_WDATA: begin
                      rem_r <= rem_r - 8'h01;
                      tx_r  <= wd1_r;
                      st_r  <= (rem_r == 8'h01) ? H_STOP : H_WDATA;
                    end
                    H_ADDRR: begin
                      tx_r <= 8'hff;
                      st_r <= H_RDATA;
                    end
                    default: begin
                      o_rd_valid <= 1'b1;
                      o_rd_data  <= rx_r;
                      rem_r      <= rem_r - 8'h01;
                      tx_r       <= 8'hff;
                      st_r       <= (rem_r == 8'h01) ? H_STOP : H_RDATA; // [RQ14]
                    end
                  endcase
                end
              end
            end
          endcase
        end
        H_STOP: if (tick) begin
          phase_r <= phase_r + 2'h1;
          unique case (phase_r)
            2'h0: sda_oe_n_r <= 1'b0;
            2'h1: scl_oe_n_r <= 1'b1;
            2'h2: sda_oe_n_r <= 1'b1; // [RQ6]
            2'h3: begin
              st_r   <= H_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
            end
          endcase
        end
      endcase
    end
  end
endmodule // setws_host
`default_nettype wire

// *** dv/setws_checker.sv ***
// Concurrent checks on the two-wire link between bus master and EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module setws_checker #(
  parameter logic [7:0] P_QTR_LAST = 8'h3f
) (
  // Clocks and reset
  input  wire logic i_clock,
  input  wire logic i_link_clk,
  input  wire logic i_rst_n,
  // Link signals
  input  wire logic scl_oe_n,
  input  wire logic h_sda_oe_n,
  input  wire logic d_sda_oe_n,
  input  wire logic scl,
  input  wire logic sda
);
  localparam int HI_MIN = 2 * (int'(P_QTR_LAST) + 1) - 1;
  logic        scl_q_r;
  logic        sda_q_r;
  logic        started_r;
  int unsigned hi_cnt_r;
  int unsigned lo_cnt_r;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  // Frame flag follows START and STOP as seen on the wires
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      started_r <= 1'b0;
    end else if (scl && scl_q_r && sda_q_r && !sda) begin
      started_r <= 1'b1;
    end else if (scl && scl_q_r && !sda_q_r && sda) begin
      started_r <= 1'b0;
    end
  end

  // Counters instead of long repetitions, which the tools unroll
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt_r <= 0;
      lo_cnt_r <= 0;
    end else begin
      hi_cnt_r <= scl ? hi_cnt_r + 1 : 0;
      lo_cnt_r <= scl ? 0 : lo_cnt_r + 1;
    end
  end

  property p_hi_len;
    @(posedge i_clock) disable iff (!i_rst_n) $fell(scl) |-> hi_cnt_r >= HI_MIN;
  endproperty
  a_hi_len: assert property (p_hi_len) else $error("clock high period too short");
  property p_lo_len;
    @(posedge i_clock) disable iff (!i_rst_n) $rose(scl) |-> lo_cnt_r >= HI_MIN;
  endproperty
  a_lo_len: assert property (p_lo_len) else $error("clock low period too short");
  property p_open;
    @(posedge i_clock) disable iff (!i_rst_n) $fell(scl) |-> started_r;
  endproperty
  a_open: assert property (p_open) else $error("clock pulse outside a frame");
  property p_stop_idle;
    @(posedge i_clock) disable iff (!i_rst_n) !started_r |-> scl;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("clock not idle after stop");
  property p_dev_idle;
    @(posedge i_clock) disable iff (!i_rst_n) !started_r |-> d_sda_oe_n;
  endproperty
  a_dev_idle: assert property (p_dev_idle) else $error("slave drives data outside a frame");
  property p_dev_low;
    @(posedge i_link_clk) disable iff (!i_rst_n) $changed(d_sda_oe_n) |-> !scl && !$past(scl);
  endproperty
  a_dev_low: assert property (p_dev_low) else $error("slave changed data with clock high");
  property p_ctl_by_host;
    @(posedge i_clock) disable iff (!i_rst_n)
      scl && scl_q_r && $changed(sda) |-> $changed(h_sda_oe_n);
  endproperty
  a_ctl_by_host: assert property (p_ctl_by_host) else $error("data change with clock high not by master");
  property p_host_rst;
    @(posedge i_clock) disable iff (!i_rst_n) $rose(i_rst_n) |-> scl_oe_n && h_sda_oe_n;
  endproperty
  a_host_rst: assert property (p_host_rst) else $error("master lines not released after reset");
  property p_dev_rst;
    @(posedge i_link_clk) disable iff (!i_rst_n) $rose(i_rst_n) |-> d_sda_oe_n;
  endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("slave data not released after reset");

  c_start: cover property (@(posedge i_clock) $rose(started_r));
  c_ack:   cover property (@(posedge i_link_clk) $fell(d_sda_oe_n));
  c_stop:  cover property (@(posedge i_clock) $fell(started_r));
endmodule // setws_checker
`default_nettype wire

// *** dv/test_serial_eeprom_two_wire_slave.sv ***
// Testbench joining master and slave ends over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module test_serial_eeprom_two_wire_slave;
  import setws_pkg::*;
  localparam logic [7:0] QL     = 8'h3f;
  localparam logic [2:0] CHIP   = 3'h5;
  localparam int         RC_CYC = 2000;  // Long enough to overlap a second frame
  logic       i_clock, link_clk, i_rst_n, rc_in, chg_q;
  logic       cmd_valid, cmd_read, cmd_set_addr;
  logic [2:0] cmd_chip;
  logic [7:0] cmd_addr, cmd_count, cmd_w0, cmd_w1;
  logic       o_busy, o_done, o_nack, o_rd_valid, o_ew_busy, o_ew_charge;
  logic [7:0] o_rd_data;
  logic [7:0] rq[$];
  int         n_mismatch, check_count, cyc, rc_cnt;
  logic [7:0] n_chg;

  setws_if link_if ();
  setws_host #(.P_QTR_LAST(QL)) i_setws_host (.link(link_if), .i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_cmd_valid(cmd_valid), .i_cmd_read(cmd_read), .i_cmd_set_addr(cmd_set_addr), .i_cmd_chip(cmd_chip),
    .i_cmd_addr(cmd_addr), .i_cmd_count(cmd_count), .i_cmd_wdata0(cmd_w0), .i_cmd_wdata1(cmd_w1),
    .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
  setws_dev i_setws_dev (.link(link_if), .i_link_clk(link_clk), .i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_chip_select_strap_bit0(CHIP[0]), .i_chip_select_strap_bit1(CHIP[1]),
    .i_chip_select_strap_bit2(CHIP[2]), .i_write_timing_network_input(rc_in),
    .o_ew_busy(o_ew_busy), .o_ew_charge(o_ew_charge));
  setws_checker #(.P_QTR_LAST(QL)) i_setws_checker (.i_clock(i_clock), .i_link_clk(link_clk),
    .i_rst_n(i_rst_n), .scl_oe_n(link_if.scl_oe_n), .h_sda_oe_n(link_if.h_sda_oe_n),
    .d_sda_oe_n(link_if.d_sda_oe_n), .scl(link_if.scl), .sda(link_if.sda));

  always #5 i_clock = ~i_clock;
  always #3 link_clk = ~link_clk;

  // RC network: comparator follows the charge control after a fixed delay
  always @(negedge i_clock) begin
    if (o_ew_charge !== rc_in) begin
      rc_cnt++;
      if (rc_cnt == RC_CYC) begin
        rc_in <= o_ew_charge;
        rc_cnt = 0;
      end
    end else begin
      rc_cnt = 0;
    end
  end

  always @(posedge i_clock) begin
    if (o_ew_charge === 1'b1 && chg_q !== 1'b1) n_chg++;
    chg_q = o_ew_charge;
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One master command; read bytes are collected into rq
  task automatic cmd(input logic rd, input logic sa, input logic [2:0] ch, input logic [7:0] ad,
                     input logic [7:0] cn, input logic [7:0] w0, input logic [7:0] w1);
    @(negedge i_clock);
    {cmd_read, cmd_set_addr, cmd_chip, cmd_addr, cmd_count, cmd_w0, cmd_w1} = {rd, sa, ch, ad, cn, w0, w1};
    cmd_valid = 1'b1;
    // A hang here is caught by the cycle watchdog
    while (o_busy !== 1'b1) @(negedge i_clock);
    cmd_valid = 1'b0;
    rq.delete();
    while (o_done !== 1'b1) begin
      @(posedge i_clock);
      #1;
      if (o_rd_valid === 1'b1) rq.push_back(o_rd_data);
    end
  endtask

  task automatic wait_ew(input logic [7:0] n_exp);
    int n;
    n = 0;
    while (o_ew_busy !== 1'b1 && n < 200) begin
      @(negedge i_clock);
      n++;
    end
    chk("ew_busy_start", 8'h01, {7'h0, o_ew_busy});
    while (o_ew_busy !== 1'b0) @(negedge i_clock);
    repeat (20) @(negedge i_clock);
    chk("charge_periods", n_exp, n_chg);
  endtask

  task automatic t_write_pair;
    n_chg = 0;
    cmd(1'b0, 1'b1, CHIP, 8'hff, 8'h02, 8'h3c, 8'ha5);
    chk("write_nack", 8'h00, {7'h0, o_nack});
    wait_ew(8'h02);
  endtask

  task automatic t_read_wrap;
    cmd(1'b1, 1'b1, CHIP, 8'hff, 8'h02, 8'h00, 8'h00);
    chk("read_count", 8'h02, 8'(rq.size()));
    chk("read_at_top", 8'h3c, rq[0]);
    chk("read_wrapped", 8'ha5, rq[1]);
  endtask

  // Last byte was not acknowledged, so the pointer stays on it
  task automatic t_read_current;
    cmd(1'b1, 1'b0, CHIP, 8'h00, 8'h01, 8'h00, 8'h00);
    chk("read_current", 8'ha5, rq[0]);
    chk("read_nack", 8'h00, {7'h0, o_nack});
  endtask

  task automatic t_write_refused;
    n_chg = 0;
    cmd(1'b0, 1'b1, CHIP, 8'h10, 8'h01, 8'h5a, 8'h00);
    chk("single_nack", 8'h00, {7'h0, o_nack});
    cmd(1'b0, 1'b1, CHIP, 8'h11, 8'h01, 8'h77, 8'h00);
    chk("busy_nack", 8'h01, {7'h0, o_nack});
    wait_ew(8'h01);
    cmd(1'b1, 1'b1, CHIP, 8'h10, 8'h01, 8'h00, 8'h00);
    chk("single_read", 8'h5a, rq[0]);
  endtask

  task automatic t_wrong_chip;
    cmd(1'b0, 1'b1, CHIP ^ 3'h1, 8'h20, 8'h01, 8'hc3, 8'h00);
    chk("chip_nack", 8'h01, {7'h0, o_nack});
    repeat (100) @(negedge i_clock);
    chk("chip_no_write", 8'h00, {7'h0, o_ew_busy});
  endtask

  initial begin
    {i_clock, link_clk, i_rst_n, rc_in, chg_q, cmd_valid} = 6'h00;
    {cmd_read, cmd_set_addr, cmd_chip, cmd_addr, cmd_count, cmd_w0, cmd_w1} = 37'h0;
    {n_mismatch, check_count, cyc, rc_cnt} = '0;
    n_chg = 8'h00;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    i_rst_n = 1'b1;
    // Slave filter needs the lines steady before the first frame
    repeat (60) @(negedge i_clock);
    t_write_pair();
    t_read_wrap();
    t_read_current();
    t_write_refused();
    t_wrong_chip();
    wrap_up();
  end
endmodule // test_serial_eeprom_two_wire_slave
`default_nettype wire
